/* File: hdl/dgio_pkg.sv */
/*
  Package for the display general I/O register bank: port addresses,
  field positions, reset values and the bus/control carriers.
  Assumes an 8-bit host I/O port bus with a 16-bit port address.
*/
package dgio_pkg;

  localparam logic [15:0] PORT_OUT_CTRL_WR = 16'h03C2;
  localparam logic [15:0] PORT_OUT_CTRL_RD = 16'h03CC;
  localparam logic [15:0] PORT_STATUS_ZERO = 16'h03C2;
  localparam logic [15:0] PORT_FEATURE = 16'h03CA;
  localparam logic [15:0] PORT_STAT1_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STAT1_COLOR = 16'h03DA;
  localparam logic [15:0] PORT_CRT_TIMING_CONTROLLER_IDX_MONO = 16'h03B4;
  localparam logic [15:0] PORT_CRT_TIMING_CONTROLLER_DAT_MONO = 16'h03B5;
  localparam logic [15:0] PORT_CRT_TIMING_CONTROLLER_IDX_COLOR = 16'h03D4;
  localparam logic [15:0] PORT_CRT_TIMING_CONTROLLER_DAT_COLOR = 16'h03D5;

  localparam int OC_COLOR_BIT = 0;
  localparam int OC_RAM_EN_BIT = 1;
  localparam int OC_CLK_LO_BIT = 2;
  localparam int OC_CLK_HI_BIT = 3;
  localparam int OC_PAGE_BIT = 5;
  localparam int OC_HPOL_BIT = 6;
  localparam int OC_VPOL_BIT = 7;
  localparam logic [7:0] OC_WR_MASK = 8'hEF;
  localparam logic [7:0] FC_WR_MASK = 8'hF8;

  localparam int S0_SENSE_BIT = 4;
  localparam int S0_VINT_BIT = 7;
  localparam int S1_DE_BIT = 0;
  localparam int S1_VR_BIT = 3;

  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    DGIO_HEIGHT_RSVD = 2'b00,
    DGIO_HEIGHT_400 = 2'b01,
    DGIO_HEIGHT_350 = 2'b10,
    DGIO_HEIGHT_480 = 2'b11
  } dgio_height_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dgio_bus_t;

  typedef struct packed {
    logic [1:0] clock_source_select_lines;
    logic color_decode;
    logic mem_decode_en;
    logic page_high;
    logic hsync_neg;
    logic vsync_neg;
    dgio_height_t height;
  } dgio_ctrl_t;

endpackage

/* File: hdl/dgio_sync.sv */
/*
  Three-stage synchroniser for one asynchronous level.
  Assumes mclk domain; the output changes once stages two and three agree.
*/
`timescale 1ns/10ps
`default_nettype none
module dgio_sync
  import dgio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);

  logic [2:0] stage_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage_q <= SYNC_RESET;
    end else begin
      stage_q <= {stage_q[1:0], async_in};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_out <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      sync_out <= stage_q[2];
    end
  end

endmodule
`default_nettype wire

/* File: hdl/dgio_regs.sv */
/*
  Display general I/O register bank: output control, two status
  registers and feature control, reached over the host I/O port bus.
  Assumes single-cycle rd/wr strobes in the mclk domain; sense, retrace
  and interrupt inputs are asynchronous, pixel outputs are on mclk.
*/
// Contract
// - output control bit 0 moves status-1 port between 3BA and 3DA.
// - output control bit 1 enables host display-memory decode.
// - output control bits 3,2 drive the clock-source select lines.
// - output control bit 5 picks low or high 64 Kbyte odd/even page.
// - bits 6,7 set sync polarities; pair 7:6 encodes monitor height.
// - reads at 3C2 return status zero; output control reads elsewhere.
// - status zero bit 4 shows the sense switch chosen by clock select.
// - status zero bit 7 is low while retrace interrupt is pending.
// - status one bit 0 is high during horizontal or vertical retrace.
// - status one bit 3 is high during vertical retrace.
// - status one bits 5:4 return a pixel pair chosen by the mux field.
// - feature control writes at 3CA and status-1 port, reads only at 3CA; bits 2-0 reserved.
// - memory decode never stalls on retrace; writes accepted anytime.
// - timing controller ports decode at 3B4/5 or 3D4/5 by bit 0.
`timescale 1ns/10ps
`default_nettype none
module dgio_regs
  import dgio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire dgio_bus_t bus,
  output logic [7:0] rdata,
  output logic rdata_valid,
  input wire logic [3:0] sense_switches,
  input wire logic vretrace_irq_pending,
  input wire logic display_blank,
  input wire logic vretrace,
  input wire logic [7:0] attr_pixels,
  input wire logic [1:0] diagnostic_pixel_select,
  input wire logic host_mem_req,
  output logic host_mem_decode,
  output logic crt_timing_controller_idx_sel,
  output logic crt_timing_controller_dat_sel,
  output dgio_ctrl_t ctrl
);

  logic [7:0] out_ctrl_q;
  logic [7:0] feature_q;
  logic [7:0] rdata_d;
  logic hit_d;
  logic [3:0] sense_sync;
  logic irq_sync;
  logic blank_sync;
  logic vr_sync;
  logic [15:0] stat1_port;
  logic sel_sense;
  logic [1:0] diag_pair;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sense
      dgio_sync u_sense (
        .mclk(mclk),
        .reset(reset),
        .async_in(sense_switches[g]),
        .sync_out(sense_sync[g])
      );
    end
  endgenerate

  dgio_sync u_irq (
    .mclk(mclk),
    .reset(reset),
    .async_in(vretrace_irq_pending),
    .sync_out(irq_sync)
  );

  dgio_sync u_blank (
    .mclk(mclk),
    .reset(reset),
    .async_in(display_blank),
    .sync_out(blank_sync)
  );

  dgio_sync u_vr (
    .mclk(mclk),
    .reset(reset),
    .async_in(vretrace),
    .sync_out(vr_sync)
  );

  function automatic logic [1:0] diag_mux(input logic [7:0] p,
                                          input logic [1:0] s);
    logic [1:0] r;
    r = 2'b00;
    case (s)
      2'b00: r = {p[2], p[0]};
      2'b01: r = {p[5], p[4]};
      2'b10: r = {p[3], p[1]};
      default: r = {p[7], p[6]};
    endcase
    return r;
  endfunction

  // status-1 and feature alias follow the emulation bit
  assign stat1_port = out_ctrl_q[OC_COLOR_BIT] ? PORT_STAT1_COLOR
                                               : PORT_STAT1_MONO;
  assign sel_sense = sense_sync[out_ctrl_q[OC_CLK_HI_BIT:OC_CLK_LO_BIT]];
  assign diag_pair = diag_mux(attr_pixels, diagnostic_pixel_select);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_ctrl_q <= OUT_CTRL_RESET;
    end else if (bus.wr && bus.addr == PORT_OUT_CTRL_WR) begin
      out_ctrl_q <= bus.wdata & OC_WR_MASK;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      feature_q <= FEATURE_RESET;
    end else if (bus.wr && (bus.addr == PORT_FEATURE ||
                            bus.addr == stat1_port)) begin
      feature_q <= bus.wdata & FC_WR_MASK;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (bus.addr == PORT_STATUS_ZERO) begin
      hit_d = 1'b1;
      rdata_d[S0_SENSE_BIT] = sel_sense;
      rdata_d[S0_VINT_BIT] = ~irq_sync;
    end else if (bus.addr == PORT_OUT_CTRL_RD) begin
      hit_d = 1'b1;
      rdata_d = out_ctrl_q;
    end else if (bus.addr == stat1_port) begin
      hit_d = 1'b1;
      rdata_d[S1_DE_BIT] = blank_sync | vr_sync;
      rdata_d[S1_VR_BIT] = vr_sync;
      rdata_d[5:4] = diag_pair;
    end else if (bus.addr == PORT_FEATURE) begin
      hit_d = 1'b1;
      rdata_d = feature_q;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata <= bus.rd ? rdata_d : 8'h00;
      rdata_valid <= bus.rd & hit_d;
    end
  end

  // memory decode depends only on the enable bit, never on retrace
  assign host_mem_decode = host_mem_req & out_ctrl_q[OC_RAM_EN_BIT];

  always_comb begin
    crt_timing_controller_idx_sel = 1'b0;
    crt_timing_controller_dat_sel = 1'b0;
    if (out_ctrl_q[OC_COLOR_BIT]) begin
      crt_timing_controller_idx_sel = bus.addr == PORT_CRT_TIMING_CONTROLLER_IDX_COLOR;
      crt_timing_controller_dat_sel = bus.addr == PORT_CRT_TIMING_CONTROLLER_DAT_COLOR;
    end else begin
      crt_timing_controller_idx_sel = bus.addr == PORT_CRT_TIMING_CONTROLLER_IDX_MONO;
      crt_timing_controller_dat_sel = bus.addr == PORT_CRT_TIMING_CONTROLLER_DAT_MONO;
    end
  end

  always_comb begin
    ctrl.clock_source_select_lines =
      out_ctrl_q[OC_CLK_HI_BIT:OC_CLK_LO_BIT];
    ctrl.color_decode = out_ctrl_q[OC_COLOR_BIT];
    ctrl.mem_decode_en = out_ctrl_q[OC_RAM_EN_BIT];
    ctrl.page_high = out_ctrl_q[OC_PAGE_BIT];
    ctrl.hsync_neg = out_ctrl_q[OC_HPOL_BIT];
    ctrl.vsync_neg = out_ctrl_q[OC_VPOL_BIT];
    ctrl.height = dgio_height_t'(out_ctrl_q[OC_VPOL_BIT:OC_HPOL_BIT]);
  end

  oc_write_a: assert property (@(posedge mclk) disable iff (reset)
    bus.wr && bus.addr == PORT_OUT_CTRL_WR |=>
      ctrl.clock_source_select_lines == $past(bus.wdata[3:2]) &&
      ctrl.page_high == $past(bus.wdata[5]))
    else $error("output control write not reflected");
  stat1_port_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == PORT_STAT1_COLOR && !ctrl.color_decode |=>
      !rdata_valid)
    else $error("colour status port answered in mono mode");
  mem_gate_a: assert property (@(posedge mclk) disable iff (reset)
    !ctrl.mem_decode_en |-> !host_mem_decode)
    else $error("memory decoded while disabled");
  page_bit_a: assert property (@(posedge mclk) disable iff (reset)
    bus.wr && bus.addr == PORT_OUT_CTRL_WR && bus.wdata[5] |=> ctrl.page_high)
    else $error("page bit not set");
  height_enc_a: assert property (@(posedge mclk) disable iff (reset)
    ctrl.height == dgio_height_t'({ctrl.vsync_neg, ctrl.hsync_neg}))
    else $error("height encoding mismatch");
  stat0_read_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == PORT_STATUS_ZERO |=>
      rdata_valid && rdata[3:0] == 4'h0 && rdata[6:5] == 2'h0)
    else $error("status zero read wrong");
  sense_sel_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == PORT_STATUS_ZERO |=> rdata[4] == $past(sel_sense))
    else $error("sense bit wrong");
  vint_low_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == PORT_STATUS_ZERO |=> rdata[7] == !$past(irq_sync))
    else $error("interrupt bit polarity wrong");
  retrace_bits_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == stat1_port && !bus.wr |=>
      rdata[0] == $past(blank_sync | vr_sync) && rdata[3] == $past(vr_sync))
    else $error("retrace bits wrong");
  diag_pair_a: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == stat1_port |=> rdata[5:4] == $past(diag_pair))
    else $error("diagnostic pair wrong");
  feat_rsvd_a: assert property (@(posedge mclk) disable iff (reset)
    feature_q[2:0] == 3'h0 && out_ctrl_q[4] == 1'b0)
    else $error("reserved bit set");

  stat0_rd_c: cover property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == PORT_STATUS_ZERO);
  color_mode_c: cover property (@(posedge mclk) disable iff (reset)
    ctrl.color_decode && bus.rd && bus.addr == PORT_STAT1_COLOR);
  mem_dec_c: cover property (@(posedge mclk) disable iff (reset)
    host_mem_decode && vr_sync);

endmodule
`default_nettype wire

/* File: tb/dgio_regs_bench.sv */
/*
  Self-checking bench for the display general I/O register bank.
  Assumes the bank answers reads one cycle after the strobe edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dgio_regs_bench
  import dgio_pkg::*;
;
  logic mclk, reset, rdata_valid, host_mem_req, host_mem_decode;
  logic irq, blank, vr, idx_sel, dat_sel;
  logic [7:0] rdata, attr;
  logic [3:0] sw;
  logic [1:0] dsel;
  dgio_bus_t bus;
  dgio_ctrl_t ctrl;
  int err_count, checked;
  int hi_idx[4] = '{2, 5, 3, 7};
  int lo_idx[4] = '{0, 4, 1, 6};

  dgio_regs i_dut (.mclk(mclk), .reset(reset), .bus(bus),
    .rdata(rdata), .rdata_valid(rdata_valid), .sense_switches(sw),
    .vretrace_irq_pending(irq), .display_blank(blank), .vretrace(vr),
    .attr_pixels(attr), .diagnostic_pixel_select(dsel),
    .host_mem_req(host_mem_req), .host_mem_decode(host_mem_decode),
    .crt_timing_controller_idx_sel(idx_sel),
    .crt_timing_controller_dat_sel(dat_sel), .ctrl(ctrl));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic acc(input logic r, w, input logic [15:0] a,
                     input logic [7:0] d, output logic [8:0] q);
    bus = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge mclk); #1;
    q = {rdata_valid, rdata};
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    @(posedge mclk); #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [8:0] q;
    acc(1'b0, 1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [15:0] a,
                    input logic [8:0] e);
    logic [8:0] q;
    acc(1'b1, 1'b0, a, 8'h00, q);
    chk(what, 16'(e), 16'(q));
  endtask

  task automatic t_out_ctrl();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      // blank needs several edges through its synchroniser before status-1 reads
      blank = i[0];
      v = {i[1:0], ~i[0], 1'b1, i[1:0], i[1], i[0]};
      wr(PORT_OUT_CTRL_WR, v);
      rd("oc read", PORT_OUT_CTRL_RD, {1'b1, v & 8'hEF});
      chk("ctrl", 16'(ctrl), 16'({i[1:0], i[0], i[1], ~i[0],
          i[0], i[1], i[1:0]}));
      host_mem_req = 1'b1;
      #1 chk("mem decode", 16'(host_mem_decode), 16'(i[1]));
      @(posedge mclk); #1;
      bus.addr = i[0] ? PORT_CRT_TIMING_CONTROLLER_IDX_COLOR : PORT_CRT_TIMING_CONTROLLER_DAT_MONO;
      #1 chk("crt_timing_controller select", 16'({idx_sel, dat_sel}),
          16'({i[0], ~i[0]}));
      rd("s1 mono", PORT_STAT1_MONO, {~i[0], 8'h00});
      rd("s1 colour", PORT_STAT1_COLOR, {i[0], 7'h00, i[0]});
    end
    $display("test out_ctrl done");
  endtask

  task automatic t_status_zero();
    for (int s = 0; s < 8; s++) begin
      wr(PORT_OUT_CTRL_WR, {4'h0, s[1:0], 2'b00});
      sw = s[2] ? ~(4'h1 << s[1:0]) : (4'h1 << s[1:0]);
      irq = s[0];
      repeat (5) @(posedge mclk);
      #1 rd("status zero", PORT_STATUS_ZERO,
          {1'b1, ~s[0], 2'b00, ~s[2], 4'h0});
    end
    $display("test status_zero done");
  endtask

  task automatic t_status_one();
    logic [1:0] m;
    wr(PORT_OUT_CTRL_WR, 8'h01);
    for (int k = 0; k < 8; k++) begin
      m = k[1:0];
      dsel = m;
      attr = k[2] ? 8'h9C : 8'h63;
      blank = m[0];
      vr = m[1];
      repeat (5) @(posedge mclk);
      #1 rd("status one", PORT_STAT1_COLOR, {3'b100, attr[hi_idx[m]],
          attr[lo_idx[m]], m[1], 2'b00, m[0] | m[1]});
    end
    $display("test status_one done");
  endtask

  task automatic t_feature();
    wr(PORT_FEATURE, 8'hFF);
    rd("feature", PORT_FEATURE, 9'h1F8);
    wr(PORT_STAT1_COLOR, 8'h57);
    rd("feature alias", PORT_FEATURE, 9'h150);
    wr(PORT_OUT_CTRL_RD, 8'hFF);
    rd("oc ro port", PORT_OUT_CTRL_RD, 9'h101);
    rd("unmapped", 16'h03C0, 9'h000);
    reset = 1'b1;
    @(posedge mclk); #1;
    reset = 1'b0;
    @(posedge mclk); #1;
    rd("oc reset", PORT_OUT_CTRL_RD, 9'h100);
    rd("feature reset", PORT_FEATURE, 9'h100);
    $display("test feature done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    bus = '0;
    sw = 4'h0;
    irq = 1'b0;
    blank = 1'b0;
    vr = 1'b0;
    attr = 8'h00;
    dsel = 2'b00;
    host_mem_req = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge mclk);
    #1 reset = 1'b0;
    @(posedge mclk); #1;
    rd("oc initial", PORT_OUT_CTRL_RD, 9'h100);
    chk("ctrl initial", 16'(ctrl), 16'h0000);
    t_out_ctrl();
    t_status_zero();
    t_status_one();
    t_feature();
    stop_test();
  end
endmodule
`default_nettype wire
